// >>> crc8_host_end.sv
// Host end: makes the bit clock, runs a measurement frame and checks its CRC-8
//
// Contract
// - CRC covers command and responses, not acks
// - Generator polynomial is x^8 + x^5 + x^4 + 1
// - Seed is reversed status low nibble, upper half
// - Bit equals bit 7: shift, insert zero
// - Bit differs: shift, flip bits 4,5, insert one
// - Receiver bit-reverses the received CRC byte
// - Receiver compares its CRC with received byte
// - On mismatch send soft reset, then remeasure; code retries at most MAX_RETRIES times, then ends with crc_error_o set
// - Catches odd, double and short burst errors
// - Sensor appends its CRC byte at the end
`timescale 1ns/100ps
`default_nettype none
module crc8_host_end #(
    parameter int RESP_BYTES  = crc8_link_pkg::RESP_BYTES,
    parameter int HALF_CYCLES = crc8_link_pkg::LINK_HALF_CYCLES,
    parameter int MAX_RETRIES = crc8_link_pkg::MAX_RETRIES
) (
    input  wire logic                    sys_clk_i,
    input  wire logic                    resetn_i,
    crc8_link_if.host_mp                 link,
    input  wire logic                    start_i,
    input  wire logic [7:0]              cmd_i,
    input  wire logic [3:0]              status_i,
    output logic                         busy_o,
    output logic                         done_o,
    output logic                         soft_reset_o,
    output logic      [8*RESP_BYTES-1:0] resp_o,
    output logic      [7:0]              crc_rx_o,
    output logic      [7:0]              crc_calc_o,
    output logic                         crc_error_o
);
    localparam int BYTE_W  = $clog2(RESP_BYTES + 2);
    localparam int DIV_W   = $clog2(2 * HALF_CYCLES);
    localparam int RETRY_W = $clog2(MAX_RETRIES + 1) + 1;
    localparam logic [BYTE_W-1:0] CRC_BYTE = BYTE_W'(RESP_BYTES + 1);
    localparam logic [DIV_W-1:0]  DIV_RISE = DIV_W'(HALF_CYCLES);
    localparam logic [DIV_W-1:0]  DIV_LAST = DIV_W'(2 * HALF_CYCLES - 1);

    crc8_link_pkg::host_state_type state;

    logic               data_meta;
    logic               data_sync;
    logic [DIV_W-1:0]   div;
    logic               running;
    logic               rise_tick;
    logic               fall_tick;
    logic               gap;
    logic               ending;
    logic               frame;
    logic               sck;
    logic               drive_low;
    logic [3:0]         bit_idx;
    logic [BYTE_W-1:0]  byte_idx;
    logic [BYTE_W-1:0]  last_byte;
    logic [7:0]         cmd_latch;
    logic [3:0]         status_latch;
    logic [7:0]         cmd_bits;
    logic [RETRY_W-1:0] retries;
    logic               data_slot;
    logic               measuring;
    logic               restart;
    logic [7:0]         restart_cmd;

    assign running   = (state != crc8_link_pkg::IDLE);
    assign measuring = (state == crc8_link_pkg::MEASURE);
    assign fall_tick = running && (div == '0);
    assign rise_tick = running && (div == DIV_RISE) && !gap;
    assign last_byte = measuring ? CRC_BYTE : '0;
    assign cmd_bits  = measuring ? cmd_latch : crc8_link_pkg::SOFT_RESET_CMD;
    assign data_slot = (bit_idx != crc8_link_pkg::ACK_BIT);

    // A relaunched frame rises on the gap's last falling tick, so its first bit must go out on that tick
    assign restart     = (state == crc8_link_pkg::SOFT_RESET)
                         || (measuring && crc_error_o && retries < RETRY_W'(MAX_RETRIES));
    assign restart_cmd = (state == crc8_link_pkg::SOFT_RESET) ? cmd_latch : crc8_link_pkg::SOFT_RESET_CMD;

    // Data pin comes from the far end; two flops before any use
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            data_meta <= 1'b1;
            data_sync <= 1'b1;
        end else begin
            data_meta <= link.data;
            data_sync <= data_meta;
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            div <= '0;
        end else if (!running || div == DIV_LAST) begin
            div <= '0;
        end else begin
            div <= div + 1'b1;
        end
    end

    // Clock made here by division, so it is no second domain at this end
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sck <= 1'b0;
        end else if (rise_tick) begin
            sck <= 1'b1;
        end else if (fall_tick) begin
            sck <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cmd_latch    <= 8'h00;
            status_latch <= 4'h0;
        end else if (!running && start_i) begin
            cmd_latch    <= cmd_i;
            status_latch <= status_i;
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state        <= crc8_link_pkg::IDLE;
            frame        <= 1'b0;
            gap          <= 1'b0;
            ending       <= 1'b0;
            bit_idx      <= 4'h0;
            byte_idx     <= '0;
            retries      <= '0;
            done_o       <= 1'b0;
            soft_reset_o <= 1'b0;
        end else begin
            done_o       <= 1'b0;
            soft_reset_o <= 1'b0;
            unique case (state)
                crc8_link_pkg::IDLE: begin
                    if (start_i) begin
                        state    <= crc8_link_pkg::MEASURE;
                        frame    <= 1'b1;
                        gap      <= 1'b0;
                        ending   <= 1'b0;
                        bit_idx  <= 4'h0;
                        byte_idx <= '0;
                        retries  <= '0;
                    end
                end
                crc8_link_pkg::MEASURE, crc8_link_pkg::SOFT_RESET: begin
                    if (rise_tick && !ending) begin
                        if (!data_slot) begin
                            bit_idx <= 4'h0;
                            if (byte_idx == last_byte) begin
                                ending <= 1'b1;
                            end else begin
                                byte_idx <= byte_idx + 1'b1;
                            end
                        end else begin
                            bit_idx <= bit_idx + 4'h1;
                        end
                    end
                    if (fall_tick && ending) begin
                        frame  <= 1'b0;
                        ending <= 1'b0;
                        gap    <= 1'b1;
                    end else if (fall_tick && gap) begin
                        gap      <= 1'b0;
                        bit_idx  <= 4'h0;
                        byte_idx <= '0;
                        if (state == crc8_link_pkg::SOFT_RESET) begin
                            state <= crc8_link_pkg::MEASURE;
                            frame <= 1'b1;
                        end else if (crc_error_o && retries < RETRY_W'(MAX_RETRIES)) begin
                            state        <= crc8_link_pkg::SOFT_RESET;
                            frame        <= 1'b1;
                            retries      <= retries + 1'b1;
                            soft_reset_o <= 1'b1;
                        end else begin
                            state  <= crc8_link_pkg::IDLE;
                            done_o <= 1'b1;
                        end
                    end
                end
                default: begin
                    state <= crc8_link_pkg::IDLE;
                end
            endcase
        end
    end

    // Host drives on the falling side; acks each response byte, not the command or CRC byte
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            drive_low <= 1'b0;
        end else if (fall_tick) begin
            if (ending) begin
                drive_low <= 1'b0;
            end else if (gap) begin
                drive_low <= restart && !restart_cmd[7];
            end else if (byte_idx == '0) begin
                drive_low <= data_slot && !cmd_bits[3'h7 - bit_idx[2:0]];
            end else begin
                drive_low <= !data_slot && (byte_idx != last_byte);
            end
        end
    end

    // Only data slots of a measurement feed the checker; ack slots are skipped
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            crc_calc_o <= crc8_link_pkg::CRC_RESET;
            crc_rx_o   <= 8'h00;
            resp_o     <= '0;
        end else if (rise_tick && measuring && data_slot && !ending) begin
            if (byte_idx == '0 && bit_idx == 4'h0) begin
                crc_calc_o <= crc8_link_pkg::crc8_step(crc8_link_pkg::crc8_seed(status_latch), data_sync);
            end else if (byte_idx < CRC_BYTE) begin
                crc_calc_o <= crc8_link_pkg::crc8_step(crc_calc_o, data_sync);
            end else begin
                crc_rx_o <= {crc_rx_o[6:0], data_sync};
            end
            if (byte_idx != '0 && byte_idx < CRC_BYTE) begin
                resp_o <= {resp_o[8*RESP_BYTES-2:0], data_sync};
            end
        end
    end

    // Checked once the whole CRC byte is in
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            crc_error_o <= 1'b0;
        end else if (!running && start_i) begin
            crc_error_o <= 1'b0;
        end else if (fall_tick && ending && measuring) begin
            crc_error_o <= (crc8_link_pkg::bit_reverse(crc_rx_o) != crc_calc_o);
        end
    end

    assign busy_o            = running;
    assign link.sck          = sck;
    assign link.frame        = frame;
    assign link.host_data_o  = 1'b0;
    assign link.host_data_oe = drive_low;

endmodule
`default_nettype wire

// >>> crc8_link_if.sv
// Three-wire sensor link: host-made bit clock, frame marker and open-drain data
`timescale 1ns/100ps
`default_nettype none
interface crc8_link_if;
    logic sck;
    logic frame;
    logic host_data_o;
    logic host_data_oe;
    logic dev_data_o;
    logic dev_data_oe;
    logic data;

    // Wired-AND with pull-up: any enabled low driver wins
    assign data = !((host_data_oe && !host_data_o) || (dev_data_oe && !dev_data_o));

    modport host_mp (
        output sck,
        output frame,
        output host_data_o,
        output host_data_oe,
        input  data
    );

    modport device_mp (
        input  sck,
        input  frame,
        input  data,
        output dev_data_o,
        output dev_data_oe
    );
endinterface
`default_nettype wire

// >>> crc8_link_pkg.sv
// Shared constants, types and CRC-8 helpers for both ends of the sensor link
package crc8_link_pkg;

    localparam int         CLK_PERIOD_NS    = 50;
    localparam int         LINK_PERIOD_NS   = 400;
    localparam int         LINK_HALF_CYCLES = (LINK_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int         RESP_BYTES       = 2;
    localparam int         MAX_RETRIES      = 1;
    localparam logic [3:0] LAST_DATA_BIT    = 4'h7;
    localparam logic [3:0] ACK_BIT          = 4'h8;
    localparam logic [7:0] SOFT_RESET_CMD   = 8'h1E;
    localparam logic [7:0] CRC_FLIP_MASK    = 8'h30;
    localparam logic [7:0] CRC_RESET        = 8'h00;

    typedef enum logic [1:0] {
        IDLE,
        MEASURE,
        SOFT_RESET
    } host_state_type;

    // Status low nibble lands reversed in the upper nibble
    function automatic logic [7:0] crc8_seed(input logic [3:0] nibble);
        crc8_seed = {nibble[0], nibble[1], nibble[2], nibble[3], 4'h0};
    endfunction

    function automatic logic [7:0] crc8_step(input logic [7:0] crc, input logic in_bit);
        if (in_bit == crc[7]) begin
            crc8_step = {crc[6:0], 1'b0};
        end else begin
            crc8_step = {crc[6:0], 1'b1} ^ CRC_FLIP_MASK;
        end
    endfunction

    function automatic logic [7:0] bit_reverse(input logic [7:0] value);
        int i;
        for (i = 0; i < 8; i++) begin
            bit_reverse[i] = value[7 - i];
        end
    endfunction

endpackage

// >>> crc8_sensor_end.sv
// Sensor end: receives the command, answers with data bytes and a CRC-8 byte
`timescale 1ns/100ps
`default_nettype none
module crc8_sensor_end #(
    parameter int RESP_BYTES = crc8_link_pkg::RESP_BYTES
) (
    input  wire logic                    resetn_i,
    crc8_link_if.device_mp               link,
    input  wire logic [3:0]              status_i,
    input  wire logic [8*RESP_BYTES-1:0] resp_i,
    output logic      [7:0]              cmd_o,
    output logic                         cmd_valid_o,
    output logic      [7:0]              crc_o
);
    localparam int BYTE_W = $clog2(RESP_BYTES + 3);
    localparam logic [BYTE_W-1:0] CRC_BYTE  = BYTE_W'(RESP_BYTES + 1);
    localparam logic [BYTE_W-1:0] PAST_LAST = BYTE_W'(RESP_BYTES + 2);

    logic              clear_n;
    logic [3:0]        bit_idx;
    logic [BYTE_W-1:0] byte_idx;
    logic [3:0]        next_bit;
    logic [BYTE_W-1:0] next_byte;
    logic [7:0]        crc;
    logic [7:0]        cmd_shift;
    logic              next_drive_low;
    logic              drive_low;
    logic              crc_slot;

    // Frame low clears all link state except cmd_o; the bit clock stands still between frames
    assign clear_n  = resetn_i & link.frame;
    assign crc_slot = (bit_idx != crc8_link_pkg::ACK_BIT) && (byte_idx < CRC_BYTE);

    always_ff @(posedge link.sck or negedge clear_n) begin
        if (!clear_n) begin
            bit_idx  <= 4'h0;
            byte_idx <= '0;
        end else begin
            bit_idx  <= next_bit;
            byte_idx <= next_byte;
        end
    end

    always_ff @(posedge link.sck or negedge clear_n) begin
        if (!clear_n) begin
            crc <= crc8_link_pkg::CRC_RESET;
        end else if (crc_slot && byte_idx == '0 && bit_idx == 4'h0) begin
            crc <= crc8_link_pkg::crc8_step(crc8_link_pkg::crc8_seed(status_i), link.data);
        end else if (crc_slot) begin
            crc <= crc8_link_pkg::crc8_step(crc, link.data);
        end
    end

    always_ff @(posedge link.sck or negedge clear_n) begin
        if (!clear_n) begin
            cmd_shift   <= 8'h00;
            cmd_valid_o <= 1'b0;
        end else begin
            cmd_valid_o <= (byte_idx == '0) && (bit_idx == crc8_link_pkg::LAST_DATA_BIT);
            if (byte_idx == '0 && bit_idx != crc8_link_pkg::ACK_BIT) begin
                cmd_shift <= {cmd_shift[6:0], link.data};
            end
        end
    end

    // Command kept past the frame so the sensor core can act on it
    always_ff @(posedge link.sck or negedge resetn_i) begin
        if (!resetn_i) begin
            cmd_o <= 8'h00;
        end else if (byte_idx == '0 && bit_idx == crc8_link_pkg::LAST_DATA_BIT) begin
            cmd_o <= {cmd_shift[6:0], link.data};
        end
    end

    always_comb begin
        int idx;
        idx            = 0;
        next_drive_low = 1'b0;
        if (bit_idx == crc8_link_pkg::ACK_BIT) begin
            next_bit  = 4'h0;
            next_byte = (byte_idx == PAST_LAST) ? byte_idx : byte_idx + 1'b1;
        end else begin
            next_bit  = bit_idx + 4'h1;
            next_byte = byte_idx;
        end
        if (next_bit == crc8_link_pkg::ACK_BIT) begin
            next_drive_low = (next_byte == '0);
        end else if (next_byte != '0 && next_byte < CRC_BYTE) begin
            idx            = 8 * RESP_BYTES - 1 - 8 * (int'(next_byte) - 1) - int'(next_bit);
            next_drive_low = !resp_i[idx];
        end else if (next_byte == CRC_BYTE) begin
            // Bit 0 goes first, so the host sees the byte reversed
            next_drive_low = !crc[next_bit[2:0]];
        end
    end

    // Drive changes right after the rising edge; the host samples a period later
    always_ff @(posedge link.sck or negedge clear_n) begin
        if (!clear_n) begin
            drive_low <= 1'b0;
        end else begin
            drive_low <= next_drive_low;
        end
    end

    assign link.dev_data_o  = 1'b0;
    assign link.dev_data_oe = drive_low;
    assign crc_o            = crc;

endmodule
`default_nettype wire

// >>> crc8_wire_checker.sv
// Wire-level timing and slot-ownership assertions for the sensor link
`timescale 1ns/100ps
`default_nettype none
module crc8_wire_checker #(
    parameter int RESP_BYTES = crc8_link_pkg::RESP_BYTES
) (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic sck,
    input wire logic frame,
    input wire logic host_data_o,
    input wire logic host_data_oe,
    input wire logic dev_data_o,
    input wire logic dev_data_oe,
    input wire logic data
);
    localparam int LAST_SLOT = 9 * (RESP_BYTES + 2);

    logic sck_q;
    logic rise;
    int   slot;

    assign rise = sck && !sck_q;

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sck_q <= 1'b0;
        end else begin
            sck_q <= sck;
        end
    end

    // Index of the slot sampled at this rise; sensor outputs seen here already belong to the next slot
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            slot <= 0;
        end else if (!frame) begin
            slot <= 0;
        end else if (rise) begin
            slot <= slot + 1;
        end
    end

    sequence s_high_phase;
        sck [*4] ##1 !sck;
    endsequence

    sequence s_low_phase;
        !sck [*4] ##1 sck;
    endsequence

    a_sck_idle_low: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        !frame |-> !sck) else $error("link clock high outside a frame");
    a_sck_high_phase: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        $rose(sck) |-> s_high_phase) else $error("link clock high phase has wrong length");
    a_sck_low_phase: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        $fell(sck) && frame |-> s_low_phase) else $error("link clock low phase has wrong length");
    a_idle_gap: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        $fell(frame) |-> (!frame) [*8]) else $error("frame gap shorter than one link period");
    a_frame_length: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        $fell(frame) |-> (slot == 9) || (slot == LAST_SLOT)) else $error("frame has wrong slot count");
    a_host_ack_slots: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        rise && slot >= 8 |-> host_data_oe == (slot % 9 == 8 && slot > 8 && slot < LAST_SLOT - 1))
        else $error("host drives the line in the wrong slot");
    a_dev_ack_slots: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        rise && slot % 9 == 7 |-> dev_data_oe == (slot == 7)) else $error("sensor drive wrong around ack");
    a_dev_quiet_cmd: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        rise && slot < 7 |-> !dev_data_oe) else $error("sensor drives during command");
    a_sck_in_frame: assert property (@(posedge sck) disable iff (!resetn_i)
        frame) else $error("link clock edge outside a frame");
    a_open_drain_line: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        !host_data_o && !dev_data_o && (data == !(host_data_oe || dev_data_oe)))
        else $error("data line does not follow the open-drain drivers");
endmodule
`default_nettype wire

// >>> serial_sensor_crc8_checker_test.sv
// Self-checking bench: host and sensor ends joined on one link
`timescale 1ns/100ps
`default_nettype none
module serial_sensor_crc8_checker_test;
    typedef struct {
        logic [7:0]  calc;
        logic [7:0]  rx;
        logic        err;
        logic [15:0] resp;
        logic [7:0]  cmd;
    } note_type;

    logic        sys_clk;
    logic        resetn;
    logic        start;
    logic [7:0]  cmd;
    logic [3:0]  host_status;
    logic [3:0]  sens_status;
    logic [15:0] resp;
    logic        busy, done, soft_reset, crc_error, cmd_valid;
    logic [15:0] resp_seen;
    logic [7:0]  crc_rx, crc_calc, sens_cmd, sens_crc;
    note_type    notes[$];
    note_type    got;
    logic [7:0]  cmds[$];
    int          resets_seen = 0;
    int          num_errors = 0;
    int          total_checks = 0;
    integer      seed = 12;

    crc8_link_if crc8_link_if_inst ();

    crc8_host_end crc8_host_end_inst (
        .sys_clk_i (sys_clk), .resetn_i (resetn), .link (crc8_link_if_inst.host_mp),
        .start_i (start), .cmd_i (cmd), .status_i (host_status),
        .busy_o (busy), .done_o (done), .soft_reset_o (soft_reset), .resp_o (resp_seen),
        .crc_rx_o (crc_rx), .crc_calc_o (crc_calc), .crc_error_o (crc_error)
    );

    crc8_sensor_end crc8_sensor_end_inst (
        .resetn_i (resetn), .link (crc8_link_if_inst.device_mp), .status_i (sens_status),
        .resp_i (resp), .cmd_o (sens_cmd), .cmd_valid_o (cmd_valid), .crc_o (sens_crc)
    );

    crc8_wire_checker crc8_wire_checker_inst (
        .sys_clk_i (sys_clk), .resetn_i (resetn), .sck (crc8_link_if_inst.sck),
        .frame (crc8_link_if_inst.frame), .host_data_o (crc8_link_if_inst.host_data_o),
        .host_data_oe (crc8_link_if_inst.host_data_oe), .dev_data_o (crc8_link_if_inst.dev_data_o),
        .dev_data_oe (crc8_link_if_inst.dev_data_oe), .data (crc8_link_if_inst.data)
    );

    function automatic logic [7:0] ref_crc(input logic [3:0] s, input logic [23:0] bits);
        logic [7:0] c;
        c = {s[0], s[1], s[2], s[3], 4'h0};
        for (int i = 23; i >= 0; i--) begin
            c = (bits[i] == c[7]) ? {c[6:0], 1'b0} : ({c[6:0], 1'b1} ^ 8'h30);
        end
        return c;
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] expected);
        total_checks++;
        if (seen !== expected) begin
            num_errors++;
            $display("[ERR] %0t seen %0h expected %0h", $time, seen, expected);
        end
    endtask

    task automatic finish_test;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Notes the expected outcome, launches one measurement, returns once idle again
    task automatic run(input logic [7:0] c, input logic [3:0] hs, input logic [3:0] ss, input logic [15:0] r);
        note_type   n;
        logic [7:0] dev_crc;
        dev_crc = ref_crc(ss, {c, r});
        n.calc = ref_crc(hs, {c, r});
        n.rx = {<<{dev_crc}};
        n.err = (n.calc != dev_crc);
        n.resp = r;
        n.cmd = c;
        notes.push_back(n);
        @(posedge sys_clk);
        cmd <= c;
        host_status <= hs;
        sens_status <= ss;
        resp <= r;
        start <= 1'b1;
        @(posedge sys_clk);
        start <= 1'b0;
        @(negedge sys_clk);
        while (busy !== 1'b0) begin
            @(negedge sys_clk);
        end
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    always @(posedge crc8_link_if_inst.sck) begin
        if (cmd_valid === 1'b1) begin
            cmds.push_back(sens_cmd);
        end
    end

    always @(posedge sys_clk) begin
        if (soft_reset === 1'b1) begin
            resets_seen++;
        end
        if (done === 1'b1 && notes.size() == 0) begin
            check(16'h0001, 16'h0000);
        end else if (done === 1'b1) begin
            got = notes.pop_front();
            check(16'(crc_calc), 16'(got.calc));
            check(16'(crc_rx), 16'(got.rx));
            check(16'(crc_error), 16'(got.err));
            check(resp_seen, got.resp);
            check(16'(sens_crc), 16'h0000);
            check(16'(resets_seen), 16'(got.err));
            check(16'(cmds.size()), got.err ? 16'h0003 : 16'h0001);
            foreach (cmds[i]) begin
                check(16'(cmds[i]), (got.err && i == 1) ? 16'h001E : 16'(got.cmd));
            end
            cmds.delete();
            resets_seen = 0;
        end
    end

    // Worst case is about 700 cycles per measurement with one retry
    initial begin
        repeat (20000) @(posedge sys_clk);
        num_errors++;
        finish_test();
    end

    initial begin
        logic [7:0]  c;
        logic [15:0] r;
        logic [3:0]  hs;
        logic [3:0]  ss;
        resetn = 1'b0;
        start = 1'b0;
        cmd = 8'h00;
        host_status = 4'h0;
        sens_status = 4'h0;
        resp = 16'h0000;
        repeat (3) @(posedge sys_clk);
        resetn <= 1'b1;
        run(8'h05, 4'h0, 4'h0, 16'h0931);
        check(16'(crc_calc), 16'h0058);
        check(16'(crc_rx), 16'h001A);
        for (int i = 0; i < 12; i++) begin
            c = 8'($random(seed));
            r = 16'($random(seed));
            hs = 4'($random(seed));
            ss = (i % 3 == 0) ? hs ^ (4'h1 << (i % 4)) : ((i % 3 == 1) ? hs ^ 4'h5 : hs);
            run(c, hs, ss, r);
        end
        repeat (2) @(posedge sys_clk);
        finish_test();
    end
endmodule
`default_nettype wire
